// ==== verilog/ppm_pkg.sv ====
`default_nettype none
package ppm_pkg;
  localparam int unsigned PPM_PINS = 8;
  localparam int unsigned PPM_FN   = 3;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IOC_LSB  = 4;
  localparam logic [11:0] ADDR_B_DATA = 12'h000;
  localparam logic [11:0] ADDR_B_LAT  = 12'h004;
  localparam logic [11:0] ADDR_B_DIR  = 12'h008;
  localparam logic [11:0] ADDR_B_ANA  = 12'h00c;
  localparam logic [11:0] ADDR_B_WPU  = 12'h010;
  localparam logic [11:0] ADDR_B_IOC  = 12'h014;
  localparam logic [11:0] ADDR_A_DATA = 12'h018;
  localparam logic [11:0] ADDR_A_LAT  = 12'h01c;
  localparam logic [11:0] ADDR_A_DIR  = 12'h020;
  localparam logic [11:0] ADDR_A_ANA  = 12'h024;
  localparam logic [7:0]  RST_LAT     = 8'h00;
  localparam logic [7:0]  RST_DIR     = 8'hff;
  localparam logic [7:0]  RST_B_ANA   = 8'h3f;
  localparam logic [7:0]  RST_B_DIGI  = 8'h00;
  localparam logic [7:0]  RST_A_ANA   = 8'h2f;
  localparam logic [7:0]  RST_WPU     = 8'h00;
  localparam logic [3:0]  RST_IOC     = 4'h0;
  localparam logic [2:0]  FN_NONE     = 3'h0;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
  typedef enum logic [2:0] {
    BOOT_WAIT = 3'b001,
    BOOT_SYNC = 3'b010,
    BOOT_DONE = 3'b100
  } ppm_boot_t;
endpackage : ppm_pkg
`default_nettype wire

// ==== verilog/ppm_prio_sel.sv ====
`default_nettype none
module ppm_prio_sel
  import ppm_pkg::*;
#(
  parameter int unsigned N = PPM_FN
)
(
  // Functions, index 0 ranks highest
  input  wire logic [N-1:0] fn_en,
  input  wire logic [N-1:0] fn_dat,
  // Port latch fallback
  input  wire logic         latch_val,
  input  wire logic         dir_in,
  // Pad drive
  output logic              drv,
  output logic              oe
);
  always_comb
  begin
    drv = latch_val;
    oe  = ~dir_in;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (fn_en[i])
      begin
        drv = fn_dat[i];
        oe  = 1'b1;
      end
    end
  end
endmodule : ppm_prio_sel
`default_nettype wire

// ==== verilog/ppm_port_mux.sv ====
`default_nettype none
module ppm_port_mux
  import ppm_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Port A pads
  input  wire logic [7:0]  pad_a_in,
  output logic [7:0]       pad_a_out,
  output logic [7:0]       pad_a_oe,
  // Port B pads
  input  wire logic [7:0]  pad_b_in,
  output logic [7:0]       pad_b_out,
  output logic [7:0]       pad_b_oe,
  // Power-on strap, digital default for port B
  input  wire logic        port_b_analog_default,
  // Port A peripheral outputs
  input  wire logic        set_reset_latch_true_out_en,
  input  wire logic        set_reset_latch_true_out,
  input  wire logic        set_reset_latch_inverted_out_en,
  input  wire logic        set_reset_latch_inverted_out,
  input  wire logic        comparator_one_output_en,
  input  wire logic        comparator_one_output,
  input  wire logic        comparator_two_output_en,
  input  wire logic        comparator_two_output,
  input  wire logic        capture_compare_unit_five_en,
  input  wire logic        capture_compare_unit_five,
  input  wire logic        oscillator_output_en,
  input  wire logic        oscillator_output,
  input  wire logic        instruction_clock_out_en,
  input  wire logic        instruction_clock_out,
  // Port B peripheral outputs
  input  wire logic        capture_compare_unit_four_en,
  input  wire logic        capture_compare_unit_four,
  input  wire logic        second_i2c_clock_en,
  input  wire logic        second_i2c_clock,
  input  wire logic        second_spi_clock_en,
  input  wire logic        second_spi_clock,
  input  wire logic        pwm_one_output_c_en,
  input  wire logic        pwm_one_output_c,
  input  wire logic        second_i2c_data_en,
  input  wire logic        second_i2c_data,
  input  wire logic        pwm_one_output_b_en,
  input  wire logic        pwm_one_output_b,
  input  wire logic        second_spi_data_out_en,
  input  wire logic        second_spi_data_out,
  input  wire logic        capture_compare_unit_two_en,
  input  wire logic        capture_compare_unit_two,
  input  wire logic        pwm_two_output_a_en,
  input  wire logic        pwm_two_output_a,
  input  wire logic        pwm_one_output_d_en,
  input  wire logic        pwm_one_output_d,
  input  wire logic        capture_compare_unit_three_en,
  input  wire logic        capture_compare_unit_three,
  input  wire logic        pwm_three_output_a_en,
  input  wire logic        pwm_three_output_a,
  input  wire logic        pwm_two_output_b_en,
  input  wire logic        pwm_two_output_b,
  input  wire logic        programming_clock_en,
  input  wire logic        programming_clock,
  input  wire logic        second_serial_tx_or_clock_en,
  input  wire logic        second_serial_tx_or_clock,
  input  wire logic        programming_data_en,
  input  wire logic        programming_data,
  input  wire logic        second_serial_rx_or_data_en,
  input  wire logic        second_serial_rx_or_data,
  // Pad control and input paths
  output logic [7:0]       analog_in_en_a,
  output logic [7:0]       analog_in_en_b,
  output logic [7:0]       digital_in_a,
  output logic [7:0]       digital_in_b,
  output logic [7:0]       pullup_en_b,
  output logic [3:0]       ioc_enable_b
);
  logic [7:0]      a_lat;
  logic [7:0]      a_dir;
  logic [7:0]      a_ana;
  logic [7:0]      port_b_output_latch;
  logic [7:0]      port_b_direction;
  logic [7:0]      b_ana;
  logic [7:0]      b_wpu;
  logic [3:0]      b_ioc;
  logic [7:0]      a_s1;
  logic [7:0]      a_s2;
  logic [7:0]      b_s1;
  logic [7:0]      b_s2;
  logic            strap_s1;
  logic            strap_s2;
  ppm_boot_t       boot_st;
  ppm_boot_t       next_boot_st;
  logic [2:0]      fn_en  [16];
  logic [2:0]      fn_dat [16];
  logic [15:0]     mux_drv;
  logic [15:0]     mux_oe;
  logic [15:0]     all_lat;
  logic [15:0]     all_dir;
  logic            wr;
  logic            rd_setup;
  logic [31:0]     next_prdata;
  logic            next_pslverr;

  assign wr       = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable;
  // Zero wait states; data was registered in the setup cycle
  assign pready   = 1'b1;

  // Pads are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_s1     <= RST_LAT;
      a_s2     <= RST_LAT;
      b_s1     <= RST_LAT;
      b_s2     <= RST_LAT;
    end
    else
    begin
      a_s1     <= pad_a_in;
      a_s2     <= a_s1;
      b_s1     <= pad_b_in;
      b_s2     <= b_s1;
    end
  end

  // No reset here, so a settled strap level is waiting when reset lifts
  always_ff @(posedge pclk)
  begin
    strap_s1 <= port_b_analog_default;
    strap_s2 <= strap_s1;
  end

  // Strap is caught once the synchroniser holds a real sample
  always_comb
  begin
    case (boot_st)
      BOOT_WAIT: next_boot_st = BOOT_SYNC;
      BOOT_SYNC: next_boot_st = BOOT_DONE;
      BOOT_DONE: next_boot_st = BOOT_DONE;
      default:   next_boot_st = BOOT_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_st <= BOOT_WAIT;
    else
      boot_st <= next_boot_st;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      b_ana <= RST_B_ANA;
    else if (boot_st == BOOT_SYNC && strap_s2)
      b_ana <= RST_B_DIGI;
    else if (wr && paddr == ADDR_B_ANA)
      b_ana <= pwdata[7:0];
  end

  // Port B registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_b_output_latch <= RST_LAT;
      port_b_direction    <= RST_DIR;
      b_wpu               <= RST_WPU;
      b_ioc               <= RST_IOC;
    end
    else if (wr)
    begin
      case (paddr)
        ADDR_B_DATA: port_b_output_latch <= pwdata[7:0];
        ADDR_B_LAT:  port_b_output_latch <= pwdata[7:0];
        ADDR_B_DIR:  port_b_direction    <= pwdata[7:0];
        ADDR_B_WPU:  b_wpu               <= pwdata[7:0];
        ADDR_B_IOC:  b_ioc               <= pwdata[7:IOC_LSB];
        default:     ;
      endcase
    end
  end

  // Port A registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_lat <= RST_LAT;
      a_dir <= RST_DIR;
      a_ana <= RST_A_ANA;
    end
    else if (wr)
    begin
      case (paddr)
        ADDR_A_DATA: a_lat <= pwdata[7:0];
        ADDR_A_LAT:  a_lat <= pwdata[7:0];
        ADDR_A_DIR:  a_dir <= pwdata[7:0];
        ADDR_A_ANA:  a_ana <= pwdata[7:0];
        default:     ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    next_prdata  = RD_ZERO;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_B_DATA: next_prdata[7:0] = digital_in_b;
      ADDR_B_LAT:  next_prdata[7:0] = port_b_output_latch;
      ADDR_B_DIR:  next_prdata[7:0] = port_b_direction;
      ADDR_B_ANA:  next_prdata[7:0] = b_ana;
      ADDR_B_WPU:  next_prdata[7:0] = b_wpu;
      ADDR_B_IOC:  next_prdata[7:IOC_LSB] = b_ioc;
      ADDR_A_DATA: next_prdata[7:0] = digital_in_a;
      ADDR_A_LAT:  next_prdata[7:0] = a_lat;
      ADDR_A_DIR:  next_prdata[7:0] = a_dir;
      ADDR_A_ANA:  next_prdata[7:0] = a_ana;
      default:     next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= RD_ZERO;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata  <= pwrite ? RD_ZERO : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Input paths and pad controls
  assign digital_in_a   = a_s2 & ~a_ana;
  assign digital_in_b   = b_s2 & ~b_ana;
  assign analog_in_en_a = a_ana;
  assign analog_in_en_b = b_ana;
  assign ioc_enable_b   = b_ioc;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pullup_en_b <= RST_WPU;
    else
      pullup_en_b <= b_wpu & port_b_direction;
  end

  // Function lists per pin, highest rank in bit 0; analog mode does not gate them
  always_comb
  begin
    for (int p = 0; p < 16; p++)
    begin
      fn_en[p]  = FN_NONE;
      fn_dat[p] = FN_NONE;
    end
    fn_en[4]   = {capture_compare_unit_five_en, comparator_one_output_en,
                  set_reset_latch_true_out_en};
    fn_dat[4]  = {capture_compare_unit_five, comparator_one_output,
                  set_reset_latch_true_out};
    fn_en[5]   = {1'b0, comparator_two_output_en, set_reset_latch_inverted_out_en};
    fn_dat[5]  = {1'b0, comparator_two_output, set_reset_latch_inverted_out};
    fn_en[6]   = {1'b0, instruction_clock_out_en, oscillator_output_en};
    fn_dat[6]  = {1'b0, instruction_clock_out, oscillator_output};
    fn_en[8]   = {2'b00, capture_compare_unit_four_en};
    fn_dat[8]  = {2'b00, capture_compare_unit_four};
    fn_en[9]   = {pwm_one_output_c_en, second_spi_clock_en, second_i2c_clock_en};
    fn_dat[9]  = {pwm_one_output_c, second_spi_clock, second_i2c_clock};
    fn_en[10]  = {1'b0, pwm_one_output_b_en, second_i2c_data_en};
    fn_dat[10] = {1'b0, pwm_one_output_b, second_i2c_data};
    fn_en[11]  = {pwm_two_output_a_en, capture_compare_unit_two_en,
                  second_spi_data_out_en};
    fn_dat[11] = {pwm_two_output_a, capture_compare_unit_two, second_spi_data_out};
    fn_en[12]  = {2'b00, pwm_one_output_d_en};
    fn_dat[12] = {2'b00, pwm_one_output_d};
    fn_en[13]  = {pwm_two_output_b_en, pwm_three_output_a_en,
                  capture_compare_unit_three_en};
    fn_dat[13] = {pwm_two_output_b, pwm_three_output_a, capture_compare_unit_three};
    fn_en[14]  = {1'b0, second_serial_tx_or_clock_en, programming_clock_en};
    fn_dat[14] = {1'b0, second_serial_tx_or_clock, programming_clock};
    fn_en[15]  = {1'b0, second_serial_rx_or_data_en, programming_data_en};
    fn_dat[15] = {1'b0, second_serial_rx_or_data, programming_data};
  end

  assign all_lat = {port_b_output_latch, a_lat};
  assign all_dir = {port_b_direction, a_dir};

  for (genvar g = 0; g < 16; g++)
  begin : g_pin
    ppm_prio_sel #(.N(PPM_FN)) u_sel (
      .fn_en     (fn_en[g]),
      .fn_dat    (fn_dat[g]),
      .latch_val (all_lat[g]),
      .dir_in    (all_dir[g]),
      .drv       (mux_drv[g]),
      .oe        (mux_oe[g])
    );
  end

  // Registered pad drive costs one cycle but keeps pads glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_a_out <= RST_LAT;
      pad_a_oe  <= RST_LAT;
      pad_b_out <= RST_LAT;
      pad_b_oe  <= RST_LAT;
    end
    else
    begin
      pad_a_out <= mux_drv[7:0];
      pad_a_oe  <= mux_oe[7:0];
      pad_b_out <= mux_drv[15:8];
      pad_b_oe  <= mux_oe[15:8];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence

  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  AST_B_DATA_WR: assert property (s_wr(ADDR_B_DATA) |=>
    port_b_output_latch == $past(pwdata[7:0]))
    else $error("data write did not reach latch");
  AST_B_LAT_RD: assert property (s_rd(ADDR_B_LAT) |=>
    prdata[7:0] == $past(port_b_output_latch))
    else $error("latch read returned wrong value");
  AST_B_ANA_ZERO: assert property (s_rd(ADDR_B_DATA) |=>
    (prdata[7:0] & $past(b_ana)) == 8'h00)
    else $error("analog pin read nonzero");
  AST_A4_PRIO: assert property (set_reset_latch_true_out_en |=>
    pad_a_oe[4] && pad_a_out[4] == $past(set_reset_latch_true_out))
    else $error("pin a4 priority wrong");
  AST_B1_PRIO: assert property (second_i2c_clock_en |=>
    pad_b_oe[1] && pad_b_out[1] == $past(second_i2c_clock))
    else $error("pin b1 priority wrong");
  AST_B5_ANALOG: assert property (b_ana[5] && capture_compare_unit_three_en |=>
    pad_b_oe[5] && pad_b_out[5] == $past(capture_compare_unit_three))
    else $error("analog pin lost digital output");
  AST_B0_LATCH: assert property (!capture_compare_unit_four_en |=>
    pad_b_oe[0] == !$past(port_b_direction[0])
    && pad_b_out[0] == $past(port_b_output_latch[0]))
    else $error("latch fallback wrong on b0");
  AST_PULLUP_OFF: assert property (##1 (pullup_en_b & ~$past(port_b_direction)) == 8'h00)
    else $error("pull-up on for output pin");
  AST_STRAP: assert property (boot_st == BOOT_SYNC |=>
    b_ana == ($past(strap_s2) ? RST_B_DIGI : RST_B_ANA))
    else $error("analog default wrong after reset");
  AST_IOC_WR: assert property (s_wr(ADDR_B_IOC) |=>
    ioc_enable_b == $past(pwdata[7:IOC_LSB]))
    else $error("change enable write lost");
  AST_ANA_WR: assert property (s_wr(ADDR_B_ANA) && boot_st == BOOT_DONE |=>
    analog_in_en_b == $past(pwdata[7:0]))
    else $error("analog select write lost");
endmodule : ppm_port_mux
`default_nettype wire

// ==== tb/ppm_pad_model.sv ====
`default_nettype none
module ppm_pad_model
(
  // Clock
  input  wire logic       pclk,
  // Device drive
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  // Outside driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Level seen by the device
  output logic [7:0]      pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_pat = 8'h55;
  // Floating pins toggle so a stale level never passes
  always_ff @(posedge pclk)
    float_pat <= ~float_pat;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : float_pat[i]);
  end
endmodule : ppm_pad_model
`default_nettype wire

// ==== tb/ppm_port_mux_tb_top.sv ====
`default_nettype none
module ppm_port_mux_tb_top import ppm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        strap = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, ioc;
  logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, ana_a, ana_b, dig_a, dig_b, pu_b;
  logic [7:0]  xe_a, xv_a, xe_b, xv_b;
  logic [7:0]  lat_a = 8'h00;
  logic [7:0]  dir_a = 8'hff;
  logic [7:0]  lat_b, dir_b;
  logic [16:0] be, bd;
  logic [6:0]  ae, ad;
  int          mismatches, compares;
  localparam int B_ST[8] = '{0, 1, 4, 6, 9, 10, 13, 15};
  localparam int B_CN[8] = '{1, 3, 2, 3, 1, 3, 2, 2};
  localparam int A_ST[8] = '{0, 0, 0, 0, 0, 3, 5, 0};
  localparam int A_CN[8] = '{0, 0, 0, 0, 3, 2, 2, 0};

  always #5 pclk = ~pclk;

  ppm_port_mux ppm_port_mux_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .pad_a_in(pa_in), .pad_a_out(pa_out), .pad_a_oe(pa_oe), .pad_b_in(pb_in),
    .pad_b_out(pb_out), .pad_b_oe(pb_oe), .port_b_analog_default(strap),
    .set_reset_latch_true_out_en(ae[0]), .set_reset_latch_true_out(ad[0]),
    .comparator_one_output_en(ae[1]), .comparator_one_output(ad[1]),
    .capture_compare_unit_five_en(ae[2]), .capture_compare_unit_five(ad[2]),
    .set_reset_latch_inverted_out_en(ae[3]), .set_reset_latch_inverted_out(ad[3]),
    .comparator_two_output_en(ae[4]), .comparator_two_output(ad[4]),
    .oscillator_output_en(ae[5]), .oscillator_output(ad[5]),
    .instruction_clock_out_en(ae[6]), .instruction_clock_out(ad[6]),
    .capture_compare_unit_four_en(be[0]), .capture_compare_unit_four(bd[0]),
    .second_i2c_clock_en(be[1]), .second_i2c_clock(bd[1]),
    .second_spi_clock_en(be[2]), .second_spi_clock(bd[2]),
    .pwm_one_output_c_en(be[3]), .pwm_one_output_c(bd[3]),
    .second_i2c_data_en(be[4]), .second_i2c_data(bd[4]),
    .pwm_one_output_b_en(be[5]), .pwm_one_output_b(bd[5]),
    .second_spi_data_out_en(be[6]), .second_spi_data_out(bd[6]),
    .capture_compare_unit_two_en(be[7]), .capture_compare_unit_two(bd[7]),
    .pwm_two_output_a_en(be[8]), .pwm_two_output_a(bd[8]),
    .pwm_one_output_d_en(be[9]), .pwm_one_output_d(bd[9]),
    .capture_compare_unit_three_en(be[10]), .capture_compare_unit_three(bd[10]),
    .pwm_three_output_a_en(be[11]), .pwm_three_output_a(bd[11]),
    .pwm_two_output_b_en(be[12]), .pwm_two_output_b(bd[12]),
    .programming_clock_en(be[13]), .programming_clock(bd[13]),
    .second_serial_tx_or_clock_en(be[14]), .second_serial_tx_or_clock(bd[14]),
    .programming_data_en(be[15]), .programming_data(bd[15]),
    .second_serial_rx_or_data_en(be[16]), .second_serial_rx_or_data(bd[16]),
    .analog_in_en_a(ana_a), .analog_in_en_b(ana_b), .digital_in_a(dig_a),
    .digital_in_b(dig_b), .pullup_en_b(pu_b), .ioc_enable_b(ioc)
  );
  ppm_pad_model pad_a_model (.pclk, .pad_out(pa_out), .pad_oe(pa_oe), .ext_en(xe_a),
    .ext_val(xv_a), .pad_in(pa_in));
  ppm_pad_model pad_b_model (.pclk, .pad_out(pb_out), .pad_oe(pb_oe), .ext_en(xe_b),
    .ext_val(xv_b), .pad_in(pb_in));

  // Returns {oe, out}; lowest function index ranks highest
  function automatic logic [15:0] exp_pad(input logic [16:0] en, input logic [16:0] dat,
    input logic [7:0] lat, input logic [7:0] dir, input logic is_b);
    logic [7:0] oe;
    logic [7:0] dv;
    int         st;
    int         cn;
    for (int p = 0; p < 8; p++)
    begin
      st = is_b ? B_ST[p] : A_ST[p];
      cn = is_b ? B_CN[p] : A_CN[p];
      oe[p] = ~dir[p];
      dv[p] = lat[p];
      for (int k = cn - 1; k >= 0; k--)
        if (en[st + k])
        begin
          oe[p] = 1'b1;
          dv[p] = dat[st + k];
        end
    end
    return {oe, dv & oe};
  endfunction : exp_pad

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    input logic [3:0] s, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        mismatches++;
        test_done();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    logic e;
    apb(1'b1, a, {24'h00_0000, d}, s, e);
  endtask : wr

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e,
    input logic ee);
    logic err;
    apb(1'b0, a, 32'h0000_0000, 4'h0, err);
    check(n, rd, e);
    check({n, "_err"}, 32'(err), 32'(ee));
  endtask : rdc

  task automatic chk_pads();
    logic [15:0] ea;
    logic [15:0] eb;
    repeat (2) @(posedge pclk);
    #1;
    ea = exp_pad(17'(ae), 17'(ad), lat_a, dir_a, 1'b0);
    eb = exp_pad(be, bd, lat_b, dir_b, 1'b1);
    check("a_oe", 32'(pa_oe), 32'(ea[15:8]));
    check("a_out", 32'(pa_out & ea[15:8]), 32'(ea[7:0]));
    check("b_oe", 32'(pb_oe), 32'(eb[15:8]));
    check("b_out", 32'(pb_out & eb[15:8]), 32'(eb[7:0]));
  endtask : chk_pads

  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {be, bd, ae, ad, xe_a, xv_a, xe_b, xv_b} = '0;
    mismatches = 0;
    compares = 0;
    void'($urandom(38));
    do_reset(1'b0);
    check("b_oe_rst", 32'(pb_oe), 32'h0000_0000);
    check("ana_b_rst", 32'(ana_b), 32'h0000_003f);
    check("pu_rst", 32'(pu_b), 32'h0000_0000);
    check("ana_a_rst", 32'(ana_a), 32'h0000_002f);
    rdc("dir_b", ADDR_B_DIR, 32'h0000_00ff, 1'b0);
    rdc("ana_a", ADDR_A_ANA, 32'h0000_002f, 1'b0);
    rdc("unmapped", 12'h0f0, 32'h0000_0000, 1'b1);
    xe_b <= 8'hff;
    xv_b <= 8'hff;
    xe_a <= 8'hff;
    xv_a <= 8'hff;
    repeat (3) @(posedge pclk);
    check("dig_b", 32'(dig_b), 32'h0000_00c0);
    check("dig_a", 32'(dig_a), 32'h0000_00d0);
    rdc("data_b_ana", ADDR_B_DATA, 32'h0000_00c0, 1'b0);
    lat_b = 8'($urandom);
    dir_b = 8'h00;
    wr(ADDR_B_LAT, lat_b);
    wr(ADDR_B_DIR, dir_b);
    chk_pads();
    wr(ADDR_B_ANA, 8'h00);
    dir_b = 8'hf0;
    wr(ADDR_B_DIR, dir_b);
    xv_b <= ~lat_b;
    chk_pads();
    rdc("lat_b", ADDR_B_LAT, 32'(lat_b), 1'b0);
    rdc("data_b", ADDR_B_DATA, 32'({~lat_b[7:4], lat_b[3:0]}), 1'b0);
    lat_b = 8'($urandom);
    wr(ADDR_B_DATA, lat_b);
    // Strobe low must leave the latch alone
    wr(ADDR_B_LAT, ~lat_b, 4'h0);
    rdc("lat_b_data", ADDR_B_LAT, 32'(lat_b), 1'b0);
    wr(ADDR_B_WPU, 8'hff);
    repeat (2) @(posedge pclk);
    check("pullup", 32'(pu_b), 32'h0000_00f0);
    wr(ADDR_B_IOC, 8'h50);
    repeat (2) @(posedge pclk);
    check("ioc", 32'(ioc), 32'h0000_0005);
    for (int k = 0; k < 17; k++)
    begin
      @(posedge pclk);
      be <= 17'h1_ffff << k;
      bd <= 17'($urandom);
      ae <= 7'h7f << (k % 7);
      ad <= 7'($urandom);
      chk_pads();
    end
    for (int r = 0; r < 200; r++)
    begin
      if (r % 50 == 0)
      begin
        {lat_a, dir_a, lat_b, dir_b} = $urandom;
        wr(ADDR_A_LAT, lat_a);
        wr(ADDR_A_DIR, dir_a);
        wr(ADDR_B_LAT, lat_b);
        wr(ADDR_B_DIR, dir_b);
        wr(ADDR_B_ANA, 8'($urandom));
      end
      @(posedge pclk);
      be <= 17'($urandom & $urandom);
      bd <= 17'($urandom);
      ae <= 7'($urandom & $urandom);
      ad <= 7'($urandom);
      chk_pads();
    end
    do_reset(1'b1);
    rdc("ana_b_strap", ADDR_B_ANA, 32'h0000_0000, 1'b0);
    test_done();
  end
endmodule : ppm_port_mux_tb_top
`default_nettype wire
